// file: bench/shp_link_props.sv
// assertion checker watching the five-wire host link
`timescale 1ns/1ps
`default_nettype none
module shp_link_props
  import shp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic port_sel,
  input wire logic serial_in,
  input wire logic serial_loop_out
);
  logic [6:0] low_r;
  logic [3:0] bits_r;
  logic sclk_r, first_r, rd_r, data_r;
  logic rd_now;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // cycles since the serial clock was last high; starts saturated so the first access is not a gap
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) low_r <= 7'h7F;
    else if (sclk) low_r <= 7'h00;
    else if (low_r != 7'h7F) low_r <= low_r + 7'h01;
  end

  // bit position, read flag and data phase of the current access
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {sclk_r, first_r, rd_r, data_r, bits_r} <= 8'h00;
    end else begin
      sclk_r <= sclk;
      if (sel_n) begin
        {first_r, rd_r, data_r, bits_r} <= 7'h40;
      end else if (sclk && !sclk_r) begin
        bits_r <= bits_r + 4'h1;
        first_r <= 1'b0;
        if (first_r) rd_r <= serial_in;
        if (bits_r == LAST_BIT) data_r <= 1'b1;
      end
    end
  end

  // read data phase begins at the last command rise, one sample before data_r shows it
  assign rd_now = rd_r && (data_r || (sclk && !sclk_r && bits_r == LAST_BIT));

  AST_HOST_PORT: assert property (!port_sel) else $error("link left in test mode");
  AST_LOOP_IDLE: assert property (sel_n |-> serial_loop_out == serial_in) else $error("loop not a copy");
  AST_LOOP_WRITE: assert property (!sel_n && !rd_now |-> serial_loop_out == serial_in)
    else $error("write word not looped");
  AST_CLK_IDLE: assert property (sel_n |-> !sclk) else $error("clock outside access");
  AST_SEL_SETUP: assert property ($fell(sel_n) |-> !sclk) else $error("clock with select");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*3]) else $error("clock high too short");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> (!sclk)[*3]) else $error("clock low too short");
  AST_WORD_GAP: assert property ($rose(sclk) && low_r > 7'h03
    |-> low_r >= (rd_r ? RD_GAP_LD : WR_GAP_LD)) else $error("gap before word too short");
  AST_SEL_HOLD: assert property ($rose(sel_n) |-> low_r >= HOLD_LD) else $error("select released early");
  AST_WORD_WHOLE: assert property ($rose(sel_n) |-> bits_r == FIRST_BIT) else $error("partial word");
  AST_READ_FALL: assert property ($changed(serial_loop_out) && rd_r && data_r && !sel_n |-> !sclk)
    else $error("read bit moved with clock high");
endmodule
`default_nettype wire

// file: bench/tb.sv
// self-checking bench: host end drives device end across the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  import shp_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b1, req_valid = 1'b0, req_read = 1'b0, req_step = 1'b0, wd_valid = 1'b0;
  logic req_ready, wd_ready, rd_valid, busy, reg_wr, reg_rd;
  logic [LEN_W-1:0] req_len = 8'h00;
  logic [27:0] e;
  logic [12:0] ea;
  shp_addr_type rq [$];
  shp_addr_type req_addr = 12'h000, reg_addr;
  shp_word_type wd_data = 16'h0000, reg_rdata = 16'h0000, rd_data, reg_wdata;
  shp_word_type mem [4096];
  shp_word_type model [4096];
  logic [27:0] wq [$];
  int fails = 0, cmp_count = 0;
  shp_link_if link(); // a single device on the link, so a read selects only one

  always #10 core_clk = !core_clk;

  shp_host shp_host_i (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
    .req_read(req_read), .req_step(req_step), .req_addr(req_addr), .req_len(req_len), .wd_valid(wd_valid),
    .wd_ready(wd_ready), .wd_data(wd_data), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .link(link));
  shp_device shp_device_i (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link(link));
  shp_link_props shp_link_props_i (.core_clk(core_clk), .rst_b(rst_b), .sclk(link.sclk), .sel_n(link.sel_n),
    .port_sel(link.port_sel), .serial_in(link.serial_in), .serial_loop_out(link.serial_loop_out));

  // register file behind the device; read data is ready half a cycle after the strobe, on the falling core clock
  always @(negedge core_clk) begin
    if (reg_rd) begin
      reg_rdata <= mem[reg_addr];
      ea = rq.size() ? {1'b0, rq.pop_front()} : 13'h1000;
      `CHK({1'b0, reg_addr}, ea)
    end
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
      e = wq.size() ? wq.pop_front() : 28'hFFFFFFF;
      `CHK({reg_addr, reg_wdata}, e)
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // bounded wait for 0 request ready, 1 read word, 2 write word taken
  task automatic wait_hi(input int s);
    int n;
    logic v;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      v = (s == 0) ? req_ready : (s == 1) ? rd_valid : wd_ready;
    end while (v !== 1'b1 && n < 400);
    if (v !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask

  // one access through the host port; written words go to the model, read words are compared
  task automatic access(input logic rd, input logic step, input shp_addr_type a, input int len, input shp_word_type d);
    shp_addr_type x;
    // reads fetch the commanded address, and with step each next one, one beyond the last
    if (rd) begin
      for (int i = 0; i <= len; i++) begin
        if (i == 0 || step) rq.push_back(a + 12'(i));
      end
    end
    @(negedge core_clk);
    {req_valid, req_read, req_step, req_addr, req_len} = {1'b1, rd, step, a, LEN_W'(len)};
    wait_hi(0);
    @(negedge core_clk);
    req_valid = 1'b0;
    `CHK(busy, 1'b1)
    for (int i = 0; i < len; i++) begin
      x = a + 12'(i);
      if (rd) begin
        wait_hi(1);
        `CHK(rd_data, step ? model[x] : {model[x][15:1], 1'b0})
      end else begin
        wd_data = d + 16'(i);
        wd_valid = 1'b1;
        model[x] = wd_data;
        wq.push_back({x, wd_data});
        wait_hi(2);
      end
      @(negedge core_clk);
    end
    wd_valid = 1'b0;
  endtask

  initial begin
    shp_addr_type b;
    void'($urandom(81));
    // a real falling reset edge before the first clock, so the link-clock flops start known
    #1 rst_b = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    // stepped burst out and back, random base and data
    b = shp_addr_type'($urandom) & 12'hFF0;
    access(1'b0, 1'b1, b, 4, shp_word_type'($urandom));
    access(1'b1, 1'b1, b, 4, 16'h0000);
    $display("test stepped burst done");
    // single words with odd data; single read loses the lsb, stepped pair keeps it
    b = b + 12'h008;
    access(1'b0, 1'b0, b, 1, 16'hFFFF);
    access(1'b0, 1'b0, b + 12'h001, 1, 16'h0001);
    access(1'b1, 1'b0, b, 1, 16'h0000);
    access(1'b1, 1'b1, b, 2, 16'h0000);
    $display("test single words done");
    // reset in mid command; the device must start fresh on the next access
    @(negedge core_clk);
    {req_valid, req_read, req_step, req_addr, req_len} = {1'b1, 1'b0, 1'b0, b, 8'h01};
    wait_hi(0);
    repeat (40) @(negedge core_clk);
    {req_valid, rst_b} = 2'b00;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    `CHK(link.sel_n, 1'b1)
    access(1'b0, 1'b1, b, 2, 16'hA5A4);
    access(1'b1, 1'b1, b, 2, 16'h0000);
    wait_hi(0);
    `CHK(wq.size(), 0)
    `CHK(rq.size(), 0)
    `CHK(busy, 1'b0)
    $display("test reset abort done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: rtl/shp_device.sv
// device end of the serial host register port
`timescale 1ns/1ps
`default_nettype none
module shp_device (
  input wire logic core_clk,
  input wire logic rst_b,
  output logic reg_wr,
  output logic reg_rd,
  output shp_pkg::shp_addr_type reg_addr,
  output shp_pkg::shp_word_type reg_wdata,
  input wire shp_pkg::shp_word_type reg_rdata,
  shp_link_if.dev link
);
  import shp_pkg::*;

  logic link_rst_n;
  logic [CNT_W-1:0] bit_r;
  shp_word_type shift_r;
  shp_word_type word_in;
  logic data_ph_r;
  logic rd_r;
  logic step_r;
  shp_addr_type addr_r;
  logic word_end;
  logic ev_fire;
  logic ev_tgl_r;
  logic ev_rd_r;
  logic ev_step_r;
  shp_addr_type ev_addr_r;
  shp_word_type ev_data_r;
  logic [CNT_W-1:0] rd_pos_r;
  logic [2:0] ev_sync_r;
  logic ev_seen;
  logic step_hold_r;
  logic rd_pend_r;
  shp_word_type rdata_r;

  // link logic only runs while this port is chosen and selected
  assign link_rst_n = rst_b & ~link.sel_n & ~link.port_sel;
  assign word_in = {shift_r[WORD_W-2:0], link.serial_in};
  assign word_end = (bit_r == LAST_BIT);

  // frame state, sampled on the rising serial clock
  always_ff @(posedge link.sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_r <= FIRST_BIT;
      shift_r <= '0;
      data_ph_r <= 1'b0;
      rd_r <= 1'b0;
      step_r <= 1'b0;
      addr_r <= '0;
    end else begin
      bit_r <= bit_r + 1'b1;
      shift_r <= word_in;
      if (word_end && !data_ph_r) begin
        data_ph_r <= 1'b1;
        rd_r <= word_in[RW_POS];
        step_r <= word_in[STEP_POS];
        addr_r <= word_in[ADDR_W-1:0];
      end else if (word_end && step_r) begin
        addr_r <= addr_r + 1'b1;
      end
    end
  end

  // a word event: a finished write word, or a read address to fetch
  always_comb begin
    ev_fire = 1'b0;
    if (word_end && !data_ph_r) begin
      ev_fire = word_in[RW_POS];
    end else if (word_end) begin
      ev_fire = !rd_r || step_r;
    end
  end

  // event toggle and payload; reset only by rst_b so a select edge
  // never looks like a toggle to the core side
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      ev_tgl_r <= 1'b0;
      ev_rd_r <= 1'b0;
      ev_step_r <= 1'b0;
      ev_addr_r <= '0;
      ev_data_r <= '0;
    end else if (ev_fire) begin
      ev_tgl_r <= ~ev_tgl_r;
      ev_data_r <= word_in;
      if (!data_ph_r) begin
        ev_rd_r <= 1'b1;
        ev_step_r <= word_in[STEP_POS];
        ev_addr_r <= word_in[ADDR_W-1:0];
      end else begin
        ev_rd_r <= rd_r;
        ev_step_r <= step_r;
        ev_addr_r <= rd_r ? addr_r + 1'b1 : addr_r;
      end
    end
  end

  // read bit position moves on the falling serial clock only, so the pin
  // never shows a stale bit while the clock is high after a word boundary
  always_ff @(negedge link.sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_pos_r <= FIRST_BIT;
    end else begin
      rd_pos_r <= bit_r;
    end
  end

  // loop-through is purely combinational; a selected read puts its data on the same pin
  always_comb begin
    link.serial_loop_out = link.serial_in;
    if (link.port_sel) begin
      link.serial_loop_out = 1'b0;
    end else if (!link.sel_n && data_ph_r && rd_r) begin
      link.serial_loop_out = rdata_r[~rd_pos_r];
    end
  end

  // toggle crossing into the core domain
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_sync_r <= 3'h0;
    end else begin
      ev_sync_r <= {ev_sync_r[1:0], ev_tgl_r};
    end
  end
  assign ev_seen = ev_sync_r[2] ^ ev_sync_r[1];

  // register access strobes; payload is stable for a whole word time
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= '0;
      reg_wdata <= '0;
      step_hold_r <= 1'b0;
    end else begin
      reg_wr <= ev_seen && !ev_rd_r;
      reg_rd <= ev_seen && ev_rd_r;
      if (ev_seen) begin
        reg_addr <= ev_addr_r;
        reg_wdata <= ev_data_r;
        step_hold_r <= ev_step_r;
      end
    end
  end

  // read data lands two cycles after reg_rd; host wait covers the latency
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      rd_pend_r <= reg_rd;
      if (rd_pend_r) begin
        rdata_r <= {reg_rdata[WORD_W-1:1], reg_rdata[0] & step_hold_r};
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/shp_host.sv
// host end of the serial host register port, makes the serial clock
//
// Contract
// - port-select low picks host port, high JTAG
// - loop output is unclocked copy of input
// - host starts and ends every access
// - 16-bit command: rw, step, 12-bit address
// - device samples command bits on rising clock
// - without step, exactly one data word
// - with step, addresses rise by one
// - single read returns zero lsb
// - host should read two registers with step
// - data msb first on rising clock
// - read waits four pixel clocks before data
// - device drives read bits on falling clock
// - write waits one pixel clock between words
// - stepped writes keep gap between data words
// - written words appear on loop output
// - all selected devices take same write
// - only one device selected during read
// - serial clock at most 10 MHz
// - unlocked gaps 445 ns write, 1187 read
// - select held low after last falling edge
`timescale 1ns/1ps
`default_nettype none
module shp_host (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic req_step,
  input wire shp_pkg::shp_addr_type req_addr,
  input wire logic [shp_pkg::LEN_W-1:0] req_len,
  input wire logic wd_valid,
  output logic wd_ready,
  input wire shp_pkg::shp_word_type wd_data,
  output logic rd_valid,
  output shp_pkg::shp_word_type rd_data,
  output logic busy,
  shp_link_if.host link
);
  import shp_pkg::*;

  typedef enum {
    SHP_IDLE,
    SHP_SETUP,
    SHP_CMD,
    SHP_GAP,
    SHP_DATA,
    SHP_HOLD,
    SHP_SPACE
  } shp_hstate_type;

  shp_hstate_type state_r;
  logic [1:0] rx_sync_r;
  logic [DIV_W-1:0] div_r;
  logic tick;
  logic sclk_r;
  logic sel_n_r;
  logic [CNT_W-1:0] bit_r;
  shp_word_type tx_r;
  shp_word_type rx_r;
  logic [GAP_W-1:0] wait_r;
  logic rd_mode_r;
  logic [LEN_W-1:0] left_r;
  logic shifting;
  logic rise_ev;
  logic fall_ev;
  logic word_end;
  logic start;
  logic gap_done;

  // two flops on the returning pin before anything looks at it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sync_r <= 2'h0;
    end else begin
      rx_sync_r <= {rx_sync_r[0], link.serial_loop_out};
    end
  end

  // half-period divider; the clock only moves while a word shifts
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= '0;
    end else if (tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
  assign tick = (div_r == DIV_LAST);

  // strobes shared by the state machine and the shifter
  assign shifting = (state_r == SHP_CMD) || (state_r == SHP_DATA);
  assign rise_ev = shifting && tick && !sclk_r;
  assign fall_ev = shifting && tick && sclk_r;
  assign word_end = fall_ev && (bit_r == LAST_BIT);
  assign start = (state_r == SHP_IDLE) && req_valid;
  assign gap_done = (state_r == SHP_GAP) && (wait_r == '0);

  // handshakes toward the user side
  assign req_ready = (state_r == SHP_IDLE);
  assign wd_ready = gap_done && !rd_mode_r && wd_valid;
  assign busy = (state_r != SHP_IDLE);

  // access sequencing: select, command, gaps, data words, hold, spacing
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SHP_IDLE;
      sel_n_r <= 1'b1;
      wait_r <= '0;
      rd_mode_r <= 1'b0;
      left_r <= '0;
    end else begin
      case (state_r)
        SHP_IDLE: begin
          if (req_valid) begin
            state_r <= SHP_SETUP;
            sel_n_r <= 1'b0;
            rd_mode_r <= req_read;
            // a zero length still moves one word
            if (req_step && (req_len != '0)) begin
              left_r <= req_len;
            end else begin
              left_r <= LEN_W'(1);
            end
          end
        end
        SHP_SETUP: begin
          // select settles a full half period before the first rise
          if (tick) begin
            state_r <= SHP_CMD;
          end
        end
        SHP_CMD: begin
          if (word_end) begin
            state_r <= SHP_GAP;
            wait_r <= rd_mode_r ? RD_GAP_LD : WR_GAP_LD;
          end
        end
        SHP_GAP: begin
          if (wait_r != '0) begin
            wait_r <= wait_r - 1'b1;
          end else if (rd_mode_r || wd_valid) begin
            state_r <= SHP_DATA;
          end
        end
        SHP_DATA: begin
          if (word_end) begin
            left_r <= left_r - 1'b1;
            if (left_r == LEN_W'(1)) begin
              state_r <= SHP_HOLD;
              wait_r <= HOLD_LD;
            end else begin
              state_r <= SHP_GAP;
              wait_r <= rd_mode_r ? RD_GAP_LD : WR_GAP_LD;
            end
          end
        end
        SHP_HOLD: begin
          if (wait_r != '0) begin
            wait_r <= wait_r - 1'b1;
          end else begin
            state_r <= SHP_SPACE;
            sel_n_r <= 1'b1;
            wait_r <= WR_GAP_LD;
          end
        end
        SHP_SPACE: begin
          if (wait_r != '0) begin
            wait_r <= wait_r - 1'b1;
          end else begin
            state_r <= SHP_IDLE;
          end
        end
        default: begin
          state_r <= SHP_IDLE;
          sel_n_r <= 1'b1;
        end
      endcase
    end
  end

  // serial clock level and bit counter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_r <= 1'b0;
      bit_r <= FIRST_BIT;
    end else if (rise_ev) begin
      sclk_r <= 1'b1;
    end else if (fall_ev) begin
      sclk_r <= 1'b0;
      bit_r <= bit_r + 1'b1;
    end else if (!shifting) begin
      bit_r <= FIRST_BIT;
    end
  end

  // outgoing word: loaded whole, shifted on falling edges, msb first;
  // after the command of a read it has shifted to zeros
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_r <= '0;
    end else if (start) begin
      tx_r <= {req_read, req_step, CMD_RSVD, req_addr};
    end else if (wd_ready) begin
      tx_r <= wd_data;
    end else if (fall_ev) begin
      tx_r <= {tx_r[WORD_W-2:0], 1'b0};
    end
  end

  // incoming read bits, taken at our own rising edge from the synced pin;
  // the device moved them a whole half period earlier
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_r <= '0;
    end else if (rise_ev) begin
      rx_r <= {rx_r[WORD_W-2:0], rx_sync_r[1]};
    end
  end

  // one read word per pulse, data held until the next word
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= word_end && rd_mode_r && (state_r == SHP_DATA);
      if (word_end && rd_mode_r && (state_r == SHP_DATA)) begin
        rd_data <= rx_r;
      end
    end
  end

  // this end only ever drives the register port; one select means one device
  assign link.port_sel = 1'b0;
  assign link.sel_n = sel_n_r;
  assign link.sclk = sclk_r;
  assign link.serial_in = tx_r[WORD_W-1];
endmodule
`default_nettype wire

// file: rtl/shp_link_if.sv
// five-wire link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface shp_link_if;
  logic sclk;
  logic sel_n;
  logic port_sel;
  logic serial_in;
  logic serial_loop_out;

  modport host (
    output sclk,
    output sel_n,
    output port_sel,
    output serial_in,
    input serial_loop_out
  );

  modport dev (
    input sclk,
    input sel_n,
    input port_sel,
    input serial_in,
    output serial_loop_out
  );
endinterface
`default_nettype wire

// file: rtl/shp_pkg.sv
// shared constants and types for the serial host register port
package shp_pkg;
  // word layout: command and data words are both 16 bits, msb first
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 4;
  localparam int LEN_W = 8;
  localparam int RW_POS = 15;
  localparam int STEP_POS = 14;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;
  localparam logic [CNT_W-1:0] FIRST_BIT = 4'h0;
  localparam logic [1:0] CMD_RSVD = 2'h0;

  // timing, figures in ns, counts derived for the 50 MHz core clock
  localparam int CORE_PERIOD_NS = 20;
  localparam int SCLK_MIN_PERIOD_NS = 100;
  localparam int WR_GAP_NS = 445;
  localparam int RD_GAP_NS = 1187;
  localparam int SEL_HOLD_NS = 445;
  localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_NS + 2 * CORE_PERIOD_NS - 1) / (2 * CORE_PERIOD_NS);
  localparam int WR_GAP_CYC = (WR_GAP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int RD_GAP_CYC = (RD_GAP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int SEL_HOLD_CYC = (SEL_HOLD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  localparam int DIV_W = 3;
  localparam int GAP_W = 7;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF_CYC - 1);
  localparam logic [GAP_W-1:0] WR_GAP_LD = GAP_W'(WR_GAP_CYC);
  localparam logic [GAP_W-1:0] RD_GAP_LD = GAP_W'(RD_GAP_CYC);
  localparam logic [GAP_W-1:0] HOLD_LD = GAP_W'(SEL_HOLD_CYC);

  typedef logic [WORD_W-1:0] shp_word_type;
  typedef logic [ADDR_W-1:0] shp_addr_type;
endpackage
